// file: src/distributed_dma_slave_regs.sv
// Distributed DMA slave channel: registers, address and count logic
`timescale 1ns/1ps
// Notes on behaviour
// - Address write loads start address, resets zero
// - Address read returns present transfer address
// - Byte mode: address on 15..0, page above
// - Word mode: address shifted up, page bit0 dropped
// - Page register read/write, resets to zero
// - Count write sets byte length, resets zero
// - Count read returns remaining count
// - Count drops one per byte, two per word
// - Command bit two disables channel
// - Other command bits are not stored
// - Status byte at command offset, resets zero
// - Upper status nibble mirrors card request
// - Lower nibble sets at terminal count, read clears
// - Address steps up or down by direction
// - Reserved locations read zero, ignore writes
module distributed_dma_slave_regs #(
   parameter int ADDR_W = 16,
   parameter int PAGE_W = 8
) (
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_i,
   input  wire logic [3:0]             io_addr_i,
   input  wire logic                   io_wr_i,
   input  wire logic                   io_rd_i,
   input  wire logic [7:0]             io_wdata_i,
   output logic      [7:0]             io_rdata_o,
   input  wire logic                   xfer_16bit_i,
   input  wire logic                   address_direction_i,
   input  wire logic                   card_request_i,
   output logic                        phase_valid_o,
   input  wire logic                   phase_ready_i,
   output logic      [PAGE_W+ADDR_W-1:0] phase_addr_o,
   output logic                        channel_enabled_o,
   output logic                        terminal_count_o
);
   localparam int PW = PAGE_W + ADDR_W;

   logic [ADDR_W-1:0] base_addr_q;   // Programmed start address
   logic [ADDR_W-1:0] cur_addr_q;    // Address of the next transfer
   logic [PAGE_W-1:0] page_q;        // Upper address byte
   logic [15:0]       base_count_q;  // Programmed byte length
   logic [15:0]       cur_count_q;   // Bytes still to move
   logic              disable_q;     // Command disable bit
   logic [3:0]        tc_q;          // Sticky terminal count nibble
   logic              armed_q;       // Transfer programmed and not finished
   logic [7:0]        rdata_q;       // Registered read data
   logic              wr_addr_lo, wr_addr_hi, wr_count_lo, wr_count_hi;
   logic              rd_status;     // Status read, clears terminal count
   logic              gen_valid;     // Word offered to the buffer
   logic              gen_ready;     // Buffer can take a word
   logic              xfer;          // One transfer happens this cycle
   logic              last_xfer;     // This transfer ends the count
   logic [15:0]       step;          // Count decrement for this mode
   logic [PW-1:0]     phase_word;    // Address-phase value

   // Write strobe decode; reserved offsets decode to nothing
   assign wr_addr_lo  = io_wr_i && io_addr_i == dma_pkg::OFF_ADDR_LO;
   assign wr_addr_hi  = io_wr_i && io_addr_i == dma_pkg::OFF_ADDR_HI;
   assign wr_count_lo = io_wr_i && io_addr_i == dma_pkg::OFF_COUNT_LO;
   assign wr_count_hi = io_wr_i && io_addr_i == dma_pkg::OFF_COUNT_HI;
   assign rd_status   = io_rd_i && io_addr_i == dma_pkg::OFF_CMD_STAT;

   // Mode dependent decrement
   assign step = xfer_16bit_i ? dma_pkg::STEP_WORD : dma_pkg::STEP_BYTE;

   // Word mode drops page bit 0 and forces the low line to zero
   assign phase_word = xfer_16bit_i ? {page_q[PAGE_W-1:1], cur_addr_q, 1'b0}
                                    : {page_q, cur_addr_q};

   // A transfer is one word handed to the buffer; a stalled receiver halts stepping once the buffer holds two words
   assign gen_valid = armed_q && !disable_q && card_request_i;
   assign xfer      = gen_valid && gen_ready;
   assign last_xfer = cur_count_q <= step;

   // Two-entry buffer toward the bus master side
   pair_buffer #(
      .WIDTH (PW)
   ) u_phase_buf (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (gen_valid),
      .in_ready_o  (gen_ready),
      .in_data_i   (phase_word),
      .out_valid_o (phase_valid_o),
      .out_ready_i (phase_ready_i),
      .out_data_o  (phase_addr_o)
   );

   // Address pair: a write loads base and current, transfers step current
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         base_addr_q <= dma_pkg::ADDR_RESET;
         cur_addr_q  <= dma_pkg::ADDR_RESET;
      end else if (wr_addr_lo) begin
         base_addr_q[7:0] <= io_wdata_i;
         cur_addr_q       <= {base_addr_q[ADDR_W-1:8], io_wdata_i};
      end else if (wr_addr_hi) begin
         base_addr_q[ADDR_W-1:8] <= io_wdata_i;
         cur_addr_q              <= {io_wdata_i, base_addr_q[7:0]};
      end else if (xfer) begin
         cur_addr_q <= address_direction_i ? cur_addr_q - dma_pkg::ADDR_STEP
                                           : cur_addr_q + dma_pkg::ADDR_STEP;
      end
   end

   // Page register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         page_q <= dma_pkg::PAGE_RESET;
      end else if (io_wr_i && io_addr_i == dma_pkg::OFF_PAGE) begin
         page_q <= io_wdata_i;
      end
   end

   // Count pair; the last transfer lands on zero rather than wrapping
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         base_count_q <= dma_pkg::COUNT_RESET;
         cur_count_q  <= dma_pkg::COUNT_RESET;
      end else if (wr_count_lo) begin
         base_count_q[7:0] <= io_wdata_i;
         cur_count_q       <= {base_count_q[15:8], io_wdata_i};
      end else if (wr_count_hi) begin
         base_count_q[15:8] <= io_wdata_i;
         cur_count_q        <= {io_wdata_i, base_count_q[7:0]};
      end else if (xfer) begin
         cur_count_q <= last_xfer ? dma_pkg::COUNT_RESET : cur_count_q - step;
      end
   end

   // Channel armed by a count write, finished at terminal count
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         armed_q <= 1'b0;
      end else if (wr_count_lo || wr_count_hi) begin
         armed_q <= 1'b1;
      end else if (xfer && last_xfer) begin
         armed_q <= 1'b0;
      end
   end

   // Command disable bit; other bits are not stored at all
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         disable_q <= 1'b0;
      end else if (io_wr_i && io_addr_i == dma_pkg::OFF_CMD_STAT) begin
         disable_q <= io_wdata_i[dma_pkg::CMD_DISABLE_BIT];
      end
   end

   // Terminal count nibble; a set in the clearing cycle wins
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tc_q <= dma_pkg::NIBBLE_ZEROS;
      end else if (xfer && last_xfer) begin
         tc_q <= dma_pkg::NIBBLE_ONES;
      end else if (rd_status) begin
         tc_q <= dma_pkg::NIBBLE_ZEROS;
      end
   end

   // Read mux, registered; unmapped offsets return zero
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_q <= dma_pkg::BYTE_RESET;
      end else if (io_rd_i) begin
         unique case (io_addr_i)
            dma_pkg::OFF_ADDR_LO:  rdata_q <= cur_addr_q[7:0];
            dma_pkg::OFF_ADDR_HI:  rdata_q <= cur_addr_q[ADDR_W-1:8];
            dma_pkg::OFF_PAGE:     rdata_q <= page_q;
            dma_pkg::OFF_COUNT_LO: rdata_q <= cur_count_q[7:0];
            dma_pkg::OFF_COUNT_HI: rdata_q <= cur_count_q[15:8];
            // Request nibble ignores any mask; command bits never read back
            dma_pkg::OFF_CMD_STAT: rdata_q <= {card_request_i ? dma_pkg::NIBBLE_ONES
                                                              : dma_pkg::NIBBLE_ZEROS,
                                               tc_q};
            default:               rdata_q <= dma_pkg::BYTE_RESET;
         endcase
      end
   end

   assign io_rdata_o        = rdata_q;
   assign channel_enabled_o = !disable_q;
   assign terminal_count_o  = tc_q[0];

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence tc_reached_s;
      xfer && last_xfer;
   endsequence

   sequence status_read_s;
      rd_status && !(xfer && last_xfer);
   endsequence

   addr_load_a: assert property (wr_addr_lo |=> cur_addr_q[7:0] == $past(io_wdata_i))
      else $error("address low byte not loaded");
   addr_step_a: assert property (xfer && !io_wr_i |=> cur_addr_q ==
         ($past(address_direction_i) ? $past(cur_addr_q) - 16'h0001 : $past(cur_addr_q) + 16'h0001))
      else $error("address step wrong");
   count_step_a: assert property (xfer && !io_wr_i && !last_xfer |=>
         $past(cur_count_q) - cur_count_q == ($past(xfer_16bit_i) ? 16'h0002 : 16'h0001))
      else $error("count decrement wrong");
   // A count write in the terminal cycle re-arms the channel at once
   tc_set_a: assert property (tc_reached_s |=> tc_q == 4'hF &&
         (!armed_q || $past(wr_count_lo || wr_count_hi)))
      else $error("terminal count not flagged");
   tc_clear_a: assert property (status_read_s |=> tc_q == 4'h0)
      else $error("status read did not clear");
   // A disabled channel must leave the count untouched unless it is rewritten
   disable_stop_a: assert property (disable_q && !wr_count_lo && !wr_count_hi |=>
         cur_count_q == $past(cur_count_q))
      else $error("disabled channel moved its count");
   word_mode_a: assert property (xfer_16bit_i |-> phase_word[0] == 1'b0 &&
         phase_word[PW-1:ADDR_W+1] == page_q[PAGE_W-1:1])
      else $error("word mode address phase wrong");
   byte_mode_a: assert property (!xfer_16bit_i |-> phase_word == {page_q, cur_addr_q})
      else $error("byte mode address phase wrong");
   status_read_a: assert property (rd_status |=> io_rdata_o[7:4] ==
         ($past(card_request_i) ? 4'hF : 4'h0))
      else $error("request nibble wrong");
   reserved_read_a: assert property (io_rd_i && io_addr_i > 4'h8 |=> io_rdata_o == 8'h00)
      else $error("reserved offset read nonzero");
endmodule

// file: include/distributed_dma_pkg.sv
// Shared constants of the distributed DMA slave register block
package dma_pkg;
   // Byte offsets inside the 16-byte I/O region
   localparam logic [3:0] OFF_ADDR_LO  = 4'h0;
   localparam logic [3:0] OFF_ADDR_HI  = 4'h1;
   localparam logic [3:0] OFF_PAGE     = 4'h2;
   localparam logic [3:0] OFF_COUNT_LO = 4'h4;
   localparam logic [3:0] OFF_COUNT_HI = 4'h5;
   localparam logic [3:0] OFF_CMD_STAT = 4'h8;
   // Reset values
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [7:0]  PAGE_RESET  = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   // Command field: only the disable bit exists
   localparam int          CMD_DISABLE_BIT = 2;
   // Status layout: request nibble high, terminal count nibble low
   localparam logic [3:0]  NIBBLE_ONES  = 4'hF;
   localparam logic [3:0]  NIBBLE_ZEROS = 4'h0;
   // Count and address steps per transfer
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
endpackage

// file: src/pair_buffer.sv
// Two-entry valid/ready buffer for address-phase words
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   logic [WIDTH-1:0] slot_q [2];   // Storage, slot 0 is the head
   logic [1:0]       fill_q;       // Number of words held
   logic             push;         // Word accepted this cycle
   logic             pop;          // Word drained this cycle

   assign in_ready_o  = (fill_q != 2'd2);
   assign out_valid_o = (fill_q != 2'd0);
   assign out_data_o  = slot_q[0];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Occupancy
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         fill_q <= 2'd0;
      end else begin
         fill_q <= fill_q + 2'(push) - 2'(pop);
      end
   end

   // Storage shifts toward the head on a pop
   always_ff @(posedge clk_sys_i) begin
      if (pop) begin
         slot_q[0] <= (fill_q == 2'd2) ? slot_q[1] : in_data_i;
      end else if (push && fill_q == 2'd0) begin
         slot_q[0] <= in_data_i;
      end
      if (push && (fill_q == 2'd2 || (fill_q == 2'd1 && !pop))) begin
         slot_q[1] <= in_data_i;
      end
   end

   fill_bound_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) fill_q != 2'd3)
      else $error("buffer occupancy out of range");
endmodule

// file: testbench/host_consumer.sv
// Host-side consumer of address-phase words, able to stall on demand
`timescale 1ns/1ps
module host_consumer (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        stall_i,
   input  wire logic        phase_valid_i,
   input  wire logic [23:0] phase_addr_i,
   output logic             phase_ready_o
);
   logic [23:0] words [$]; // Words taken, oldest first

   // Ready drops while the bench holds a stall, so the buffer must hold words
   assign phase_ready_o = !stall_i;

   // A word is taken only at an edge where valid meets ready
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         words.delete();
      end else if (phase_valid_i && phase_ready_o) begin
         words.push_back(phase_addr_i);
      end
   end
endmodule

// file: testbench/distributed_dma_slave_regs_test.sv
// Register-level tests of the distributed DMA slave channel
`timescale 1ns/1ps
module distributed_dma_slave_regs_test;
   logic        clk_sys_i = 1'b0; // System clock, 100 MHz
   logic        rst_i     = 1'b1; // Synchronous reset
   logic [3:0]  io_addr   = 4'h0;
   logic        io_wr     = 1'b0;
   logic        io_rd     = 1'b0;
   logic [7:0]  io_wdata  = 8'h00;
   logic [7:0]  io_rdata;
   logic        word_mode = 1'b0; // 16-bit transfer mode when high
   logic        down      = 1'b0; // Address direction
   logic        card_req  = 1'b0; // Card DMA request
   logic        stall     = 1'b0; // Consumer stall
   logic        phase_valid;
   logic        phase_ready;
   logic [23:0] phase_addr;
   logic        chan_en;
   logic        tc;
   int          n_errors = 0;
   int          compares = 0;

   // Clock toggles every half period
   always #5 clk_sys_i = !clk_sys_i;

   distributed_dma_slave_regs i_distributed_dma_slave_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
      .xfer_16bit_i(word_mode), .address_direction_i(down), .card_request_i(card_req),
      .phase_valid_o(phase_valid), .phase_ready_i(phase_ready), .phase_addr_o(phase_addr),
      .channel_enabled_o(chan_en), .terminal_count_o(tc));
   host_consumer i_host_consumer (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_i(stall),
      .phase_valid_i(phase_valid), .phase_addr_i(phase_addr), .phase_ready_o(phase_ready));

   // Compare one value with its expectation
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe, launched at the falling edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk_sys_i);
      io_wr = 1'b0;
   endtask

   // Read strobe; registered data is settled by the next falling edge
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(negedge clk_sys_i);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk_sys_i);
      io_rd = 1'b0;
      chk(io_rdata, exp);
   endtask

   // Wait, under a bound, until the consumer holds n words
   task automatic wait_words(input int n);
      for (int i = 0; i < 60 && i_host_consumer.words.size() < n; i++) @(negedge clk_sys_i);
      chk(i_host_consumer.words.size(), n);
   endtask

   // Verdict and end of run
   task automatic summarize();
      $display("Counts: %0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Watchdog: the tests need about a hundred cycles
   initial begin
      #100us;
      n_errors++;
      summarize();
   end

   initial begin
      repeat (6) @(negedge clk_sys_i);
      rst_i = 1'b0;
      // Reset values, then reserved places
      rdchk(4'h0, 8'h00);
      rdchk(4'h2, 8'h00);
      rdchk(4'h5, 8'h00);
      rdchk(4'h8, 8'h00);
      chk(chan_en, 1'b1);
      wr(4'h3, 8'hFF);
      wr(4'hC, 8'hFF);
      rdchk(4'h3, 8'h00);
      rdchk(4'hC, 8'h00);
      $display("Test reset and reserved done");
      // Byte mode, upward, consumer stalling until the buffer is full
      wr(4'h2, 8'h5A);
      wr(4'h0, 8'h34);
      wr(4'h1, 8'h12);
      wr(4'h4, 8'h03);
      rdchk(4'h2, 8'h5A);
      rdchk(4'h1, 8'h12);
      stall = 1'b1;
      card_req = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      chk(phase_valid, 1'b1);
      rdchk(4'h0, 8'h36);
      rdchk(4'h4, 8'h01);
      stall = 1'b0;
      wait_words(3);
      chk(i_host_consumer.words[0], {8'h5A, 16'h1234});
      chk(i_host_consumer.words[2], {8'h5A, 16'h1236});
      chk(tc, 1'b1);
      rdchk(4'h8, 8'hFF);
      rdchk(4'h8, 8'hF0);
      card_req = 1'b0;
      rdchk(4'h8, 8'h00);
      $display("Test byte mode done");
      // Word mode, downward
      word_mode = 1'b1;
      down = 1'b1;
      wr(4'h2, 8'h5B);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h80);
      wr(4'h4, 8'h04);
      card_req = 1'b1;
      wait_words(5);
      chk(i_host_consumer.words[3], {7'h2D, 16'h8000, 1'b0});
      chk(i_host_consumer.words[4], {7'h2D, 16'h7FFF, 1'b0});
      card_req = 1'b0;
      rdchk(4'h4, 8'h00);
      rdchk(4'h0, 8'hFE);
      rdchk(4'h1, 8'h7F);
      $display("Test word mode done");
      // Disabled channel moves nothing
      wr(4'h8, 8'hFF);
      chk(chan_en, 1'b0);
      wr(4'h4, 8'h02);
      card_req = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      rdchk(4'h4, 8'h02);
      // Terminal count of the word-mode run is still pending until this read
      rdchk(4'h8, 8'hFF);
      rdchk(4'h8, 8'hF0);
      card_req = 1'b0;
      rdchk(4'h8, 8'h00);
      card_req = 1'b1;
      wr(4'h8, 8'h00);
      chk(chan_en, 1'b1);
      wait_words(6);
      card_req = 1'b0;
      $display("Test disable done");
      summarize();
   end
endmodule
